// File: rtl/aigs_cfg_sync.sv
// aigs_cfg_sync: toggle handshake carrying a configuration word into the link domain
`timescale 1ns/10ps
`default_nettype none
module aigs_cfg_sync #(
  parameter int         W       = 6,
  parameter logic [5:0] RST_VAL = 6'h00
) (
  // source side
  input  wire logic         src_clk_i,
  input  wire logic         src_rst_ni,
  input  wire logic [W-1:0] src_data_i,
  output logic              busy_o,
  // destination side
  input  wire logic         dst_clk_i,
  input  wire logic         dst_rst_ni,
  output logic [W-1:0]      dst_data_o
);
  logic [W-1:0] hold_reg;
  logic         req_reg;
  logic         ack_s1_reg;
  logic         ack_s2_reg;
  logic         req_s1_reg;
  logic         req_s2_reg;
  logic         req_s3_reg;
  logic [W-1:0] data_reg;

  assign busy_o     = req_reg ^ ack_s2_reg;
  assign dst_data_o = data_reg;

  // hold_reg stays frozen while a transfer is open, so the far side reads a stable word
  always_ff @(posedge src_clk_i or negedge src_rst_ni)
    if (!src_rst_ni)
    begin
      hold_reg <= RST_VAL[W-1:0];
      req_reg  <= 1'b0;
    end
    else if (!busy_o && (src_data_i != hold_reg))
    begin
      hold_reg <= src_data_i;
      req_reg  <= ~req_reg;
    end

  always_ff @(posedge src_clk_i or negedge src_rst_ni)
    if (!src_rst_ni)
      {ack_s2_reg, ack_s1_reg} <= 2'h0;
    else
      {ack_s2_reg, ack_s1_reg} <= {ack_s1_reg, req_s3_reg};

  always_ff @(posedge dst_clk_i or negedge dst_rst_ni)
    if (!dst_rst_ni)
      {req_s3_reg, req_s2_reg, req_s1_reg} <= 3'h0;
    else
      {req_s3_reg, req_s2_reg, req_s1_reg} <= {req_s2_reg, req_s1_reg, req_reg};

  always_ff @(posedge dst_clk_i or negedge dst_rst_ni)
    if (!dst_rst_ni)
      data_reg <= RST_VAL[W-1:0];
    else if (req_s2_reg ^ req_s3_reg)
      data_reg <= hold_reg;
endmodule : aigs_cfg_sync
`default_nettype wire

// File: rtl/aigs_dc_filter.sv
// aigs_dc_filter: first-order dc removal on one adc channel, with bypass
`timescale 1ns/10ps
`default_nettype none
module aigs_dc_filter
  import aigs_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_ni,
  // sample in
  input  wire logic          in_valid_i,
  input  wire logic [SW-1:0] in_data_i,
  input  wire logic          bypass_i,
  // sample out
  output logic               out_valid_o,
  output logic [SW-1:0]      out_data_o
);
  localparam int ACC_W = SW + HPF_SHIFT;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [SW-1:0]    dc_est;
  logic signed [SW-1:0]    diff;
  logic                    valid_reg;
  logic [SW-1:0]           data_reg;

  assign dc_est      = acc_reg[ACC_W-1:HPF_SHIFT];
  // wraps on full-scale steps; a limitation accepted for area
  assign diff        = $signed(in_data_i) - dc_est;
  assign out_valid_o = valid_reg;
  assign out_data_o  = data_reg;

  always_ff @(posedge clk_i or negedge rst_ni)
    if (!rst_ni)
      acc_reg <= '0;
    else if (in_valid_i)
      acc_reg <= acc_reg + ACC_W'(diff);

  always_ff @(posedge clk_i or negedge rst_ni)
    if (!rst_ni)
    begin
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end
    else
    begin
      valid_reg <= in_valid_i;
      if (in_valid_i)
        data_reg <= bypass_i ? in_data_i : diff; // (R10)
    end

  a_hpf_bypass: assert property (@(posedge clk_i) disable iff (!rst_ni) // (R10)
    in_valid_i && bypass_i |=> out_valid_o && out_data_o == $past(in_data_i))
    else $error("bypassed sample altered");
endmodule : aigs_dc_filter
`default_nettype wire

// File: rtl/aigs_pkg.sv
// aigs_pkg: constants and carrier types of the audio input gain and adc slot block
package aigs_pkg;
  localparam int AW = 12;
  localparam int SW = 20;
  localparam logic [6:0] IDX_BEEP  = 7'h0A;
  localparam logic [6:0] IDX_PHONE = 7'h0C;
  localparam logic [6:0] IDX_AFC   = 7'h5C;
  localparam logic [6:0] IDX_PWR   = 7'h70;
  localparam logic [6:0] IDX_RATE  = 7'h72;
  localparam logic [6:0] IDX_STAT  = 7'h74;
  // word addresses; byte address is four times the index
  localparam logic [9:0] WA_BEEP  = {3'h0, IDX_BEEP};
  localparam logic [9:0] WA_PHONE = {3'h0, IDX_PHONE};
  localparam logic [9:0] WA_AFC   = {3'h0, IDX_AFC};
  localparam logic [9:0] WA_PWR   = {3'h0, IDX_PWR};
  localparam logic [9:0] WA_RATE  = {3'h0, IDX_RATE};
  localparam logic [9:0] WA_STAT  = {3'h0, IDX_STAT};
  localparam logic [15:0] PHONE_RST  = 16'hC008;
  localparam logic [15:0] PHONE_MASK = 16'hC01F;
  localparam logic [15:0] BEEP_RST   = 16'hAAA0;
  localparam logic [15:0] BEEP_MASK  = 16'hFFF0;
  localparam logic [15:0] AFC_RST    = 16'h0000;
  localparam logic [15:0] AFC_MASK   = 16'h000B;
  localparam logic [15:0] PWR_RST    = 16'h0000;
  localparam logic [15:0] PWR_MASK   = 16'h0007;
  localparam logic [15:0] RATE_RST   = 16'hBB80;
  localparam logic [15:0] RATE_MASK  = 16'hFFFF;
  localparam int PH_HP   = 15;
  localparam int PH_SPK  = 14;
  localparam int PH_GAIN = 0;
  localparam int BP_HP   = 15;
  localparam int BP_HPG  = 12;
  localparam int BP_SPK  = 11;
  localparam int BP_SPKG = 8;
  localparam int BP_TEL  = 7;
  localparam int BP_TELG = 4;
  localparam int AFC_BYP = 3;
  localparam int AFC_SEL = 0;
  localparam int PW_L    = 0;
  localparam int PW_R    = 1;
  localparam int PW_B    = 2;
  localparam logic [3:0] SLOT_L [4] = '{4'h3, 4'h7, 4'h6, 4'hA};
  localparam logic [3:0] SLOT_R [4] = '{4'h4, 4'h8, 4'h9, 4'hB};
  localparam int HPF_SHIFT = 10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] CFG_RST     = 6'h00;

  typedef struct packed {
    logic       phone_to_hp_mute;
    logic       phone_to_spk_mute;
    logic [4:0] phone_in_gain;
  } aigs_phone_s;

  typedef struct packed {
    logic       beep_to_hp_mute;
    logic [2:0] beep_to_hp_gain;
    logic       beep_to_spk_mute;
    logic [2:0] beep_to_spk_gain;
    logic       beep_to_tel_mute;
    logic [2:0] beep_to_tel_gain;
  } aigs_beep_s;

  typedef struct packed {
    logic        left_adc_powerdown;
    logic        right_adc_powerdown;
    logic        dc_filter_bypass;
    logic [15:0] adc_rate;
  } aigs_adc_s;

  typedef struct packed {
    logic       left_adc_powerdown;
    logic       right_adc_powerdown;
    logic       both_adc_powerdown;
    logic       dc_filter_bypass;
    logic [1:0] adc_slot_select;
  } aigs_cfg_s;
endpackage : aigs_pkg

// File: rtl/aigs_top.sv
// aigs_top: phone and beep input controls, adc power, filter and slot mapping
//
// Function
// (R1) phone bit 15 mutes phone to headphone mixer; resets to 1.
// (R2) phone bit 14 mutes phone to speaker mixer; resets to 1.
// (R3) phone bits 4:0 set phone gain, +12dB down in 1.5dB steps, reset 01000.
// (R4) no control routes phone input into the phone mixer.
// (R5) beep mutes: bit 15 headphone, 11 speaker, 7 phone; 1 mutes, reset 1.
// (R6) beep gains 14:12, 10:8, 6:4; 000 is +6dB, 3dB steps, reset 010.
// (R7) adc sample rate has its own register, independent of the dac.
// (R8) left and right adc have own power-down bits; a third stops both.
// (R9) with only one adc running its sample fills both link slots.
// (R10) high-pass filter on by default; bit 3 set bypasses it.
// (R11) bits 1:0 pick slot pairs 3/4, 7/8, 6/9, 10/11; reset 00.
// (R12) controller records phone on one adc channel, microphone on other.
// (R13) undefined bits ignore writes and read zero; fields read back writes.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module aigs_top
  import aigs_pkg::*;
(
  // system clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  // axi4-lite write channels
  input  wire logic [AW-1:0] s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  // axi4-lite read channels
  input  wire logic [AW-1:0] s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  // analog path controls
  output aigs_phone_s        phone_ctl_o,
  output aigs_beep_s         beep_ctl_o,
  output aigs_adc_s          adc_ctl_o,
  // link domain: adc samples in, slot data out
  input  wire logic          link_clk_i,
  input  wire logic          adc_strobe_i,
  input  wire logic [SW-1:0] adc_left_i,
  input  wire logic [SW-1:0] adc_right_i,
  output logic               slot_strobe_o,
  output logic [12:0]        slot_tag_o,
  output logic [3:0]         slot_left_num_o,
  output logic [3:0]         slot_right_num_o,
  output logic [SW-1:0]      slot_left_data_o,
  output logic [SW-1:0]      slot_right_data_o
);
  logic        awready_reg;
  logic        wready_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [9:0]  wa_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [15:0] phone_reg;
  logic [15:0] beep_reg;
  logic [15:0] afc_reg;
  logic [15:0] pwr_reg;
  logic [15:0] rate_reg;
  aigs_adc_s   adc_ctl_reg;
  logic        aw_taken;
  logic        w_taken;
  logic        wr_do;
  logic        aw_full_next;
  logic        w_full_next;
  logic        ar_taken;
  logic        rvalid_next;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] rd_val;
  logic        sync_busy;
  logic        l_run_sys;
  logic        r_run_sys;
  aigs_cfg_s   cfg_src;
  aigs_cfg_s   cfg_l;
  logic        lrst_s1_reg;
  logic        lrst_n;
  logic        l_run;
  logic        r_run;
  logic        fl_valid;
  logic [SW-1:0] fl_data;
  logic [SW-1:0] fr_data;
  logic [12:0] tag_next;
  logic        strobe_reg;
  logic [12:0] tag_reg;
  logic [3:0]  lnum_reg;
  logic [3:0]  rnum_reg;
  logic [SW-1:0] ldata_reg;
  logic [SW-1:0] rdata_l_reg;

  // byte lanes 0 and 1 carry the 16-bit register; undefined bits masked off
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (st[0])
      v[7:0] = wd[7:0];
    if (st[1])
      v[15:8] = wd[15:8];
    return v & m;
  endfunction : merge

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  assign aw_taken     = s_axi_awvalid_i && awready_reg;
  assign w_taken      = s_axi_wvalid_i && wready_reg;
  assign wr_do        = aw_full_reg && w_full_reg && !bvalid_reg;
  assign aw_full_next = wr_do ? 1'b0 : (aw_full_reg || aw_taken);
  assign w_full_next  = wr_do ? 1'b0 : (w_full_reg || w_taken);

  // address and data are taken in either order and held until the write is done
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      wa_reg      <= 10'h000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg  <= !w_full_next;
      if (aw_taken)
        wa_reg <= s_axi_awaddr_i[AW-1:2];
      if (w_taken)
      begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
    end

  always_comb
    unique case (wa_reg)
      WA_BEEP, WA_PHONE, WA_AFC, WA_PWR, WA_RATE, WA_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_reg <= 1'b0;

  // status is read-only: a write there is accepted and dropped
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      phone_reg <= PHONE_RST; // (R1) (R2) (R3)
      beep_reg  <= BEEP_RST;  // (R5) (R6)
      afc_reg   <= AFC_RST;   // (R10) (R11)
      pwr_reg   <= PWR_RST;
      rate_reg  <= RATE_RST;
    end
    else if (wr_do)
    begin
      if (wa_reg == WA_PHONE)
        phone_reg <= merge(phone_reg, wdata_reg, wstrb_reg, PHONE_MASK); // (R1) (R2) (R3) (R4)
      if (wa_reg == WA_BEEP)
        beep_reg <= merge(beep_reg, wdata_reg, wstrb_reg, BEEP_MASK); // (R5) (R6)
      if (wa_reg == WA_AFC)
        afc_reg <= merge(afc_reg, wdata_reg, wstrb_reg, AFC_MASK); // (R10) (R11) (R13)
      if (wa_reg == WA_PWR)
        pwr_reg <= merge(pwr_reg, wdata_reg, wstrb_reg, PWR_MASK); // (R8)
      if (wa_reg == WA_RATE)
        rate_reg <= merge(rate_reg, wdata_reg, wstrb_reg, RATE_MASK); // (R7)
    end

  assign l_run_sys = !(pwr_reg[PW_L] || pwr_reg[PW_B]);
  assign r_run_sys = !(pwr_reg[PW_R] || pwr_reg[PW_B]);

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i[AW-1:2])
      WA_BEEP:  rd_val = beep_reg;
      WA_PHONE: rd_val = phone_reg;
      WA_AFC:   rd_val = afc_reg;
      WA_PWR:   rd_val = pwr_reg;
      WA_RATE:  rd_val = rate_reg;
      WA_STAT:  rd_val = {13'h0000, r_run_sys, l_run_sys, sync_busy};
      default:
      begin
        rd_hit = 1'b0;
        rd_val = 16'h0000; // (R13)
      end
    endcase
  end

  assign ar_taken    = s_axi_arvalid_i && arready_reg;
  assign rvalid_next = ar_taken || (rvalid_reg && !s_axi_rready_i);

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end
    else
    begin
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_taken)
      begin
        rdata_reg <= {16'h0000, rd_val}; // (R13)
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end

  // phone mixer route deliberately absent: no bit reaches it
  assign phone_ctl_o.phone_to_hp_mute  = phone_reg[PH_HP];          // (R1)
  assign phone_ctl_o.phone_to_spk_mute = phone_reg[PH_SPK];         // (R2) (R4)
  assign phone_ctl_o.phone_in_gain     = phone_reg[PH_GAIN+:5];     // (R3)
  assign beep_ctl_o.beep_to_hp_mute    = beep_reg[BP_HP];           // (R5)
  assign beep_ctl_o.beep_to_hp_gain    = beep_reg[BP_HPG+:3];       // (R6)
  assign beep_ctl_o.beep_to_spk_mute   = beep_reg[BP_SPK];          // (R5)
  assign beep_ctl_o.beep_to_spk_gain   = beep_reg[BP_SPKG+:3];      // (R6)
  assign beep_ctl_o.beep_to_tel_mute   = beep_reg[BP_TEL];          // (R5)
  assign beep_ctl_o.beep_to_tel_gain   = beep_reg[BP_TELG+:3];      // (R6)
  assign adc_ctl_o                     = adc_ctl_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      adc_ctl_reg <= '0;
    else
    begin
      adc_ctl_reg.left_adc_powerdown  <= !l_run_sys; // (R8)
      adc_ctl_reg.right_adc_powerdown <= !r_run_sys; // (R8)
      adc_ctl_reg.dc_filter_bypass    <= afc_reg[AFC_BYP];
      adc_ctl_reg.adc_rate            <= rate_reg; // (R7)
    end

  always_comb
  begin
    cfg_src.left_adc_powerdown  = pwr_reg[PW_L];
    cfg_src.right_adc_powerdown = pwr_reg[PW_R];
    cfg_src.both_adc_powerdown  = pwr_reg[PW_B];
    cfg_src.dc_filter_bypass    = afc_reg[AFC_BYP];
    cfg_src.adc_slot_select     = afc_reg[AFC_SEL+:2];
  end

  aigs_cfg_sync #(
    .W       ($bits(aigs_cfg_s)),
    .RST_VAL (CFG_RST)
  ) u_cfg_sync (
    .src_clk_i  (sys_clk_i),
    .src_rst_ni (resetn_i),
    .src_data_i (cfg_src),
    .busy_o     (sync_busy),
    .dst_clk_i  (link_clk_i),
    .dst_rst_ni (lrst_n),
    .dst_data_o (cfg_l)
  );

  // reset release is resynchronised so the link domain leaves reset cleanly
  always_ff @(posedge link_clk_i or negedge resetn_i)
    if (!resetn_i)
      {lrst_n, lrst_s1_reg} <= 2'h0;
    else
      {lrst_n, lrst_s1_reg} <= {lrst_s1_reg, 1'b1};

  assign l_run = !(cfg_l.left_adc_powerdown || cfg_l.both_adc_powerdown);  // (R8)
  assign r_run = !(cfg_l.right_adc_powerdown || cfg_l.both_adc_powerdown); // (R8)

  aigs_dc_filter u_filt_l (
    .clk_i       (link_clk_i),
    .rst_ni      (lrst_n),
    .in_valid_i  (adc_strobe_i),
    .in_data_i   (adc_left_i),
    .bypass_i    (cfg_l.dc_filter_bypass),
    .out_valid_o (fl_valid),
    .out_data_o  (fl_data)
  );

  aigs_dc_filter u_filt_r (
    .clk_i       (link_clk_i),
    .rst_ni      (lrst_n),
    .in_valid_i  (adc_strobe_i),
    .in_data_i   (adc_right_i),
    .bypass_i    (cfg_l.dc_filter_bypass),
    .out_valid_o (),
    .out_data_o  (fr_data)
  );

  always_comb
  begin
    tag_next = 13'h0000;
    if (l_run || r_run)
    begin
      tag_next[SLOT_L[cfg_l.adc_slot_select]] = 1'b1; // (R11)
      tag_next[SLOT_R[cfg_l.adc_slot_select]] = 1'b1; // (R11)
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n)
    if (!lrst_n)
    begin
      strobe_reg  <= 1'b0;
      tag_reg     <= 13'h0000;
      lnum_reg    <= SLOT_L[0];
      rnum_reg    <= SLOT_R[0];
      ldata_reg   <= '0;
      rdata_l_reg <= '0;
    end
    else
    begin
      strobe_reg <= fl_valid;
      if (fl_valid)
      begin
        tag_reg  <= tag_next;
        lnum_reg <= SLOT_L[cfg_l.adc_slot_select]; // (R11)
        rnum_reg <= SLOT_R[cfg_l.adc_slot_select]; // (R11)
        unique case ({l_run, r_run})
          2'b11:
          begin
            ldata_reg   <= fl_data;
            rdata_l_reg <= fr_data;
          end
          2'b10:
          begin
            ldata_reg   <= fl_data; // (R9)
            rdata_l_reg <= fl_data; // (R9)
          end
          2'b01:
          begin
            ldata_reg   <= fr_data; // (R9)
            rdata_l_reg <= fr_data; // (R9)
          end
          2'b00:
          begin
            ldata_reg   <= '0;
            rdata_l_reg <= '0;
          end
        endcase
      end
    end

  assign slot_strobe_o     = strobe_reg;
  assign slot_tag_o        = tag_reg;
  assign slot_left_num_o   = lnum_reg;
  assign slot_right_num_o  = rnum_reg;
  assign slot_left_data_o  = ldata_reg;
  assign slot_right_data_o = rdata_l_reg;

  a_phone_hp_mute: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R1)
    wr_do && wa_reg == WA_PHONE && wstrb_reg[1]
    |=> phone_ctl_o.phone_to_hp_mute == $past(wdata_reg[PH_HP]))
    else $error("headphone mute not taken from write");

  a_phone_spk_mute: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R2)
    wr_do && wa_reg == WA_PHONE && wstrb_reg[1]
    |=> phone_ctl_o.phone_to_spk_mute == $past(wdata_reg[PH_SPK]))
    else $error("speaker mute not taken from write");

  a_phone_gain_code: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R3)
    wr_do && wa_reg == WA_PHONE && wstrb_reg[0]
    |=> phone_ctl_o.phone_in_gain == $past(wdata_reg[4:0]))
    else $error("phone gain not taken from write");

  a_phone_no_tel: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R4)
    wr_do && wa_reg == WA_PHONE |=> phone_reg[13:5] == 9'h000)
    else $error("phone register kept an unused bit");

  a_beep_mute_bits: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R5)
    wr_do && wa_reg == WA_BEEP && wstrb_reg[1] && wstrb_reg[0]
    |=> {beep_ctl_o.beep_to_hp_mute, beep_ctl_o.beep_to_spk_mute, beep_ctl_o.beep_to_tel_mute}
        == {$past(wdata_reg[15]), $past(wdata_reg[11]), $past(wdata_reg[7])})
    else $error("beep mutes wrong");

  a_beep_gain_bits: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R6)
    wr_do && wa_reg == WA_BEEP && wstrb_reg[1] && wstrb_reg[0]
    |=> beep_ctl_o.beep_to_hp_gain == $past(wdata_reg[14:12])
        && beep_ctl_o.beep_to_tel_gain == $past(wdata_reg[6:4]))
    else $error("beep gains wrong");

  a_rate_own_reg: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R7)
    wr_do && wa_reg == WA_RATE && wstrb_reg[1:0] == 2'h3
    |=> ##1 adc_ctl_o.adc_rate == $past(wdata_reg[15:0], 2))
    else $error("adc rate not applied");

  a_adc_pd_left: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R8)
    wr_do && wa_reg == WA_PWR && wstrb_reg[0]
    |=> ##1 adc_ctl_o.left_adc_powerdown == ($past(wdata_reg[0], 2) | $past(wdata_reg[2], 2)))
    else $error("left adc power-down wrong");

  a_mono_duplicate: assert property (@(posedge link_clk_i) disable iff (!lrst_n) // (R9)
    fl_valid && (l_run ^ r_run)
    |=> slot_strobe_o && slot_left_data_o == slot_right_data_o && slot_tag_o != 13'h0000)
    else $error("single adc not duplicated");

  a_slot_pair: assert property (@(posedge link_clk_i) disable iff (!lrst_n) // (R11)
    fl_valid && cfg_l.adc_slot_select == 2'h2
    |=> slot_left_num_o == 4'h6 && slot_right_num_o == 4'h9)
    else $error("slot pair 6/9 wrong");

  a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // (R13)
    s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h00000000)
    else $error("unmapped read not zero");

  a_bresp_next: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_do |=> s_axi_bvalid_o)
    else $error("write response late");
endmodule : aigs_top
`default_nettype wire

// File: testbench/aigs_link_model.sv
// aigs_link_model: link-side sample source and slot capture
`timescale 1ns/10ps
`default_nettype none
module aigs_link_model
  import aigs_pkg::*;
(
  // link side
  input  wire logic          lclk_i,
  input  wire logic          sstb_i,
  input  wire logic [60:0]   slot_i,
  output logic               strb_o,
  output logic [SW-1:0]      left_o,
  output logic [SW-1:0]      right_o
);
  logic [60:0] cap;
  initial {strb_o, left_o, right_o} = '0;
  // samples scrambled off the strobe so stale data cannot pass
  // l and r stand for two different record sources, such as phone and microphone
  task automatic send(input logic [SW-1:0] l, input logic [SW-1:0] r);
    cap = 'x;
    @(posedge lclk_i);
    strb_o <= 1'b1;
    left_o <= l;
    right_o <= r;
    @(posedge lclk_i);
    strb_o <= 1'b0;
    left_o <= ~l;
    right_o <= ~r;
    for (int n = 0; n < 6; n++)
    begin
      @(posedge lclk_i);
      if (sstb_i === 1'b1) cap = slot_i;
    end
  endtask : send
endmodule : aigs_link_model
`default_nettype wire

// File: testbench/aigs_top_bench.sv
// aigs_top_bench: register, filter, slot and power scenarios for aigs_top
`timescale 1ns/10ps
`default_nettype none
module aigs_top_bench
  import aigs_pkg::*;
();
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0;
  logic bre = 1'b0, arv = 1'b0, rre = 1'b0, awr, wr_, bv, arr, rv, ss, strb;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat;
  logic [1:0] bresp, rresp;
  aigs_phone_s ph;
  aigs_beep_s bp;
  aigs_adc_s ac;
  logic [12:0] tag;
  logic [3:0] lnum, rnum, ws = 4'h3;
  logic [3:0] lt [4] = '{4'h3, 4'h7, 4'h6, 4'hA};
  logic [3:0] rt [4] = '{4'h4, 4'h8, 4'h9, 4'hB};
  logic [SW-1:0] al, ar, ld, rdd;
  int err_total = 0, checks_done = 0;
  always #25 clk = ~clk;
  initial #7 forever #40 lclk = ~lclk;
  aigs_top dut_u (.sys_clk_i(clk), .resetn_i(rst_n), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .phone_ctl_o(ph), .beep_ctl_o(bp), .adc_ctl_o(ac), .link_clk_i(lclk), .adc_strobe_i(strb),
    .adc_left_i(al), .adc_right_i(ar), .slot_strobe_o(ss), .slot_tag_o(tag),
    .slot_left_num_o(lnum), .slot_right_num_o(rnum), .slot_left_data_o(ld),
    .slot_right_data_o(rdd));
  aigs_link_model lm_u (.lclk_i(lclk), .sstb_i(ss), .slot_i({tag, lnum, rnum, ld, rdd}),
    .strb_o(strb), .left_o(al), .right_o(ar));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic stuck();
    err_total++;
    $display("Error at %0t: handshake timed out", $time);
    print_verdict();
  endtask : stuck
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] w, input logic [15:0] d);
    bit ok;
    ok = 1'b0;
    @(posedge clk);
    awa <= {w, 2'b00};
    wd <= {16'h0000, d};
    {awv, wv, bre} <= 3'h7;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_ === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) ok = 1'b1;
      if (ok) chk({62'h0, bresp}, {62'h0, RESP_OKAY});
    end
    bre <= 1'b0;
    if (!ok) stuck();
  endtask : wr
  task automatic rc(input logic [9:0] w, input logic [15:0] e, input logic [1:0] er);
    bit ok;
    ok = 1'b0;
    @(posedge clk);
    ara <= {w, 2'b00};
    {arv, rre} <= 2'h3;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) ok = 1'b1;
      if (ok) chk({30'h0, rresp, rdat}, {30'h0, er, 16'h0, e});
    end
    rre <= 1'b0;
    if (!ok) stuck();
  endtask : rc
  // config crossing takes a few link cycles
  task automatic lk(input logic [SW-1:0] l, r, el, er, input logic [12:0] t, input logic [7:0] n);
    repeat (16) @(posedge clk);
    lm_u.send(l, r);
    chk({3'h0, lm_u.cap}, {3'h0, t, n, el, er});
  endtask : lk
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rc(WA_PHONE, 16'hC008, RESP_OKAY);
    rc(WA_BEEP, 16'hAAA0, RESP_OKAY);
    rc(WA_AFC, 16'h0000, RESP_OKAY);
    chk({45'h0, ph, bp}, {45'h0, 7'h68, 12'hAAA});
    chk({45'h0, ac}, {45'h0, 3'b000, 16'hBB80});
    lk(20'h04000, 20'h04000, 20'h04000, 20'h04000, 13'h0018, 8'h34);
    lk(20'h04000, 20'h04000, 20'h03FF0, 20'h03FF0, 13'h0018, 8'h34);
    wr(WA_PHONE, 16'hFFFF);
    rc(WA_PHONE, 16'hC01F, RESP_OKAY);
    wr(WA_PHONE, 16'h0015);
    chk({57'h0, ph}, {57'h0, 7'h15});
    // upper lane only: the gain byte must survive
    ws <= 4'h2;
    wr(WA_PHONE, 16'hFFFF);
    ws <= 4'h3;
    rc(WA_PHONE, 16'hC015, RESP_OKAY);
    wr(WA_BEEP, 16'h3F4F);
    rc(WA_BEEP, 16'h3F40, RESP_OKAY);
    chk({52'h0, bp}, {52'h0, 12'h3F4});
    rc(10'h3FF, 16'h0000, RESP_SLVERR);
    wr(WA_AFC, 16'h0008);
    wr(WA_RATE, 16'h1F40);
    @(posedge clk);
    chk({45'h0, ac}, {45'h0, 3'b001, 16'h1F40});
    for (int s = 3; s >= 0; s--)
    begin
      wr(WA_AFC, 16'h0008 | 16'(s));
      rc(WA_AFC, 16'h0008 | 16'(s), RESP_OKAY);
      lk(20'h12345, 20'h6789A, 20'h12345, 20'h6789A, (13'h1 << lt[s]) | (13'h1 << rt[s]),
        {lt[s], rt[s]});
    end
    wr(WA_PWR, 16'h0001);
    lk(20'h12345, 20'h6789A, 20'h6789A, 20'h6789A, 13'h0018, 8'h34);
    rc(WA_STAT, 16'h0004, RESP_OKAY);
    wr(WA_PWR, 16'h0002);
    lk(20'h12345, 20'h6789A, 20'h12345, 20'h12345, 13'h0018, 8'h34);
    chk({45'h0, ac}, {45'h0, 3'b011, 16'h1F40});
    wr(WA_PWR, 16'h0004);
    lk(20'h12345, 20'h6789A, 20'h00000, 20'h00000, 13'h0000, 8'h34);
    print_verdict();
  end
endmodule : aigs_top_bench
`default_nettype wire
